//--- interrupt_vector_map_tb.sv
`default_nettype none
module interrupt_vector_map_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [16:0] BOOT = 17'h01C00;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        sre = 1'b0;
    logic        reloc = 1'b0;
    logic        fuse_n = 1'b1;
    logic        accept = 1'b0;
    logic        take;
    logic [27:0] req = 28'h0000000;
    logic        valid;
    logic [4:0]  idx;
    logic [16:0] addr;
    logic        rl;
    logic [16:0] ra;
    int          failures = 0;
    int          samples_checked = 0;
    ivm_vector_map #(.BOOT_ADDR(BOOT)) u_dut (.clk(clk), .reset(reset), .sys_reset_event(sre),
        .ext_request(req[7:0]), .pin_change_req(req[10:8]), .watchdog_timeout(req[11]),
        .timer_b8_evt(req[14:12]), .timer_w16_evt(req[19:15]), .timer_a8_evt(req[22:20]),
        .spi_transfer_done(req[23]), .serial0_evt(req[26:24]), .analog_cmp_evt(req[27]),
        .vector_relocate_bit(reloc), .boot_reset_fuse_n(fuse_n), .take(take), .vec_valid_r(valid),
        .vec_index_r(idx), .vec_addr_r(addr), .reset_load_r(rl), .reset_addr_r(ra));
    ivm_core_model u_core (.clk(clk), .vec_valid_r(valid), .accept(accept), .take(take));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task step;
        @(posedge clk);
        #1;
    endtask
    task chk(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task print_verdict;
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task t_boot;
        fuse_n = 1'b0;
        sre = 1'b1;
        step;
        sre = 1'b0;
        step;
        chk({16'h0000, rl}, 17'h00001);
        chk(ra, BOOT);
        fuse_n = 1'b1;
        step;
    endtask
    task t_map(input logic r);
        for (int k = 0; k < 28; k++)
        begin
            req = (28'h0000001 << k) | 28'h8000000;
            reloc = r;
            step;
            chk({16'h0000, valid}, 17'h00001);
            chk({12'h000, idx}, 17'(k + 1));
            chk(addr, (r ? BOOT : 17'h00000) + 17'((k + 1) * 2));
        end
        req = 28'h0000000;
        step;
        chk({16'h0000, valid}, 17'h00000);
    endtask
    task t_take;
        req = 28'h0000001;
        accept = 1'b1;
        step;
        chk({16'h0000, valid}, 17'h00001);
        step;
        step;
        chk({16'h0000, valid}, 17'h00000);
        accept = 1'b0;
        req = 28'h0000000;
        step;
    endtask
    initial
    begin
        #10000;
        failures++;
        print_verdict;
    end
    initial
    begin
        repeat (20) step;
        reset = 1'b0;
        step;
        chk({16'h0000, rl}, 17'h00001);
        chk(ra, 17'h00000);
        t_boot;
        t_map(1'b0);
        t_map(1'b1);
        t_take;
        print_verdict;
    end
endmodule
`default_nettype wire

//--- ivm_core_model.sv
`default_nettype none
module ivm_core_model
(
    input  wire logic clk,
    input  wire logic vec_valid_r,
    input  wire logic accept,
    output var  logic take
);
    timeunit 1ns;
    timeprecision 100ps;
    initial take = 1'b0;
    always @(posedge clk) take <= #1 accept & vec_valid_r;
endmodule
`default_nettype wire

//--- ivm_pkg.sv
`default_nettype none
package ivm_pkg;
    localparam int unsigned ADDR_W        = 17;
    localparam int unsigned NUM_IRQ       = 28;
    localparam int unsigned IDX_W         = 5;
    localparam logic [16:0] RESET_ADDR    = 17'h00000;
    localparam logic [16:0] BOOT_ADDR_DEF = 17'h1F000;
    localparam logic [16:0] VEC_SHIFT     = 17'h00001;

    typedef struct packed {
        logic        valid;
        logic [4:0]  index;
        logic [16:0] addr;
    } ivm_vec_t;

    typedef struct packed {
        logic        relocate;
        logic        boot_fuse;
        logic [16:0] boot_base;
    } ivm_cfg_t;
endpackage
`default_nettype wire

//--- ivm_prio_enc.sv
`default_nettype none
module ivm_prio_enc
#(
    parameter int unsigned N = 28
)
(
    input  wire logic [N-1:0] req,
    output logic              any,
    output logic [4:0]        index
);
    always_comb
    begin
        any   = 1'b0;
        index = 5'h00;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                any   = 1'b1;
                index = 5'(i);
            end
        end
    end
endmodule
`default_nettype wire

//--- ivm_vector_map.sv
`default_nettype none
module ivm_vector_map
#(
    parameter logic [16:0] BOOT_ADDR = ivm_pkg::BOOT_ADDR_DEF
)
(
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        sys_reset_event,
    input  wire logic [7:0]                  ext_request,
    input  wire logic [2:0]                  pin_change_req,
    input  wire logic                        watchdog_timeout,
    input  wire logic [2:0]                  timer_b8_evt,
    input  wire logic [4:0]                  timer_w16_evt,
    input  wire logic [2:0]                  timer_a8_evt,
    input  wire logic                        spi_transfer_done,
    input  wire logic [2:0]                  serial0_evt,
    input  wire logic                        analog_cmp_evt,
    input  wire logic                        vector_relocate_bit,
    input  wire logic                        boot_reset_fuse_n,
    input  wire logic                        take,
    output logic                             vec_valid_r,
    output logic [4:0]                       vec_index_r,
    output logic [ivm_pkg::ADDR_W-1:0]       vec_addr_r,
    output logic                             reset_load_r,
    output logic [ivm_pkg::ADDR_W-1:0]       reset_addr_r
);
    // ------------------------------------------------------------
    // Request vector, bit i is vector number i+1.
    // ------------------------------------------------------------
    logic [ivm_pkg::NUM_IRQ-1:0] req;
    logic                        any;
    logic [4:0]                  idx;
    logic                        boot_fuse_prog;
    logic [16:0]                 base;
    logic                        pend_reset_r;

    assign boot_fuse_prog = ~boot_reset_fuse_n;
    assign req = {analog_cmp_evt, serial0_evt, spi_transfer_done,
                  timer_a8_evt, timer_w16_evt, timer_b8_evt,
                  watchdog_timeout, pin_change_req, ext_request};

    ivm_prio_enc #(.N(ivm_pkg::NUM_IRQ)) u_enc
    (
        .req   (req),
        .any   (any),
        .index (idx)
    );

    function automatic logic [16:0] vec_addr(input logic [4:0] i, input logic [16:0] b);
        vec_addr = b + ({12'h000, i + 5'h01} << ivm_pkg::VEC_SHIFT);
    endfunction

    assign base = vector_relocate_bit ? BOOT_ADDR : ivm_pkg::RESET_ADDR;

    // ------------------------------------------------------------
    // Interrupt vector selection.
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            vec_valid_r <= 1'b0;
            vec_index_r <= 5'h00;
            vec_addr_r  <= ivm_pkg::RESET_ADDR;
        end
        else
        begin
            vec_valid_r <= any & ~take;
            vec_index_r <= idx + 5'h01;
            vec_addr_r  <= vec_addr(idx, base);
        end
    end

    // ------------------------------------------------------------
    // Reset vector.
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pend_reset_r <= 1'b1;
            reset_load_r <= 1'b0;
            reset_addr_r <= ivm_pkg::RESET_ADDR;
        end
        else
        begin
            pend_reset_r <= sys_reset_event;
            reset_load_r <= pend_reset_r;
            reset_addr_r <= boot_fuse_prog ? BOOT_ADDR : ivm_pkg::RESET_ADDR;
        end
    end

    a_reset_addr: assert property (@(posedge clk) disable iff (reset)
        reset_load_r |-> reset_addr_r == ($past(boot_reset_fuse_n) ? ivm_pkg::RESET_ADDR : BOOT_ADDR))
        else $error("reset address wrong");
    a_reset_load: assert property (@(posedge clk) disable iff (reset)
        sys_reset_event |=> ##1 reset_load_r)
        else $error("reset vector not loaded");
    a_ext_zero: assert property (@(posedge clk) disable iff (reset)
        (ext_request[0] && !vector_relocate_bit) |=> vec_addr_r == 17'h00002)
        else $error("external request zero address wrong");
    a_prio_low: assert property (@(posedge clk) disable iff (reset)
        req[0] |=> vec_index_r == 5'h01)
        else $error("priority wrong");
    a_prio_next: assert property (@(posedge clk) disable iff (reset)
        (req[1] && !req[0]) |=> vec_index_r == 5'h02)
        else $error("second priority wrong");
    a_addr_twice: assert property (@(posedge clk) disable iff (reset)
        (!$past(vector_relocate_bit)) |-> vec_addr_r == {11'h000, vec_index_r, 1'b0})
        else $error("vector address not twice index");
    a_spi_vec: assert property (@(posedge clk) disable iff (reset)
        (req[23] && req[22:0] == 23'h000000 && !vector_relocate_bit) |=> vec_addr_r == 17'h00030 && vec_index_r == 5'h18)
        else $error("serial peripheral vector wrong");
    a_wdt_vec: assert property (@(posedge clk) disable iff (reset)
        (req[11] && req[10:0] == 11'h000 && !vector_relocate_bit) |=> vec_addr_r == 17'h00018)
        else $error("watchdog vector wrong");
    a_cmp_vec: assert property (@(posedge clk) disable iff (reset)
        (req[27] && req[26:0] == 27'h0000000 && vector_relocate_bit) |=> vec_addr_r == BOOT_ADDR + 17'h00038)
        else $error("comparator vector wrong");
    a_t0_ovf: assert property (@(posedge clk) disable iff (reset)
        (req[22] && req[21:0] == 22'h000000 && !vector_relocate_bit) |=> vec_addr_r == 17'h0002E)
        else $error("timer overflow vector wrong");
endmodule
`default_nettype wire
